// ===== verilog/pmt_timer.sv
// 8-bit period match timer with prescaler, postscaler, apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module pmt_timer
	import pmt_pkg::*;
#(
	parameter int IC_DIV = PMT_IC_DIV
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// match outputs
	output logic             pwm_timebase,
	output logic             ssp_shift_clk
);

	// ==================================================
	// elaboration check
	generate
		if (IC_DIV < 1 || IC_DIV > 16) begin : g_bad_div
			$error("pmt_timer: IC_DIV must lie in 1..16");
		end
	endgenerate

	// ==================================================
	// prescale mask, shared by tick logic and checks
	function automatic logic [3:0] pre_mask(input logic [1:0] sel);
		logic [3:0] m;
		m = PMT_PRE_M16;
		if (sel == 2'b00) begin
			m = PMT_PRE_M1;
		end else if (sel == 2'b01) begin
			m = PMT_PRE_M4;
		end
		return m;
	endfunction

	// ==================================================
	// state
	logic [7:0]  count_r;
	logic [7:0]  period_r;
	logic [6:0]  control_r;
	logic        flag_r;
	logic        enable_r;
	logic [3:0]  qdiv_r;
	logic [3:0]  pre_cnt_r;
	logic [3:0]  post_cnt_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        irq_r;
	logic        match_r;
	logic        shift_r;

	// ==================================================
	// apb decode
	logic       acc;
	logic       wr_en;
	logic       rd_hit;
	logic       wr_count;
	logic       wr_period;
	logic       wr_control;
	logic       wr_flag;
	logic       wr_enable;
	logic [31:0] rd_val;

	assign acc   = psel & penable;
	assign wr_en = acc & pwrite & pready_r;

	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		if (paddr == PMT_OFS_COUNT) begin
			rd_val = {24'h000000, count_r};
		end else if (paddr == PMT_OFS_PERIOD) begin
			rd_val = {24'h000000, period_r};
		end else if (paddr == PMT_OFS_CONTROL) begin
			rd_val = {25'h0000000, control_r};
		end else if (paddr == PMT_OFS_FLAG) begin
			rd_val = {31'h00000000, flag_r};
		end else if (paddr == PMT_OFS_ENABLE) begin
			rd_val = {31'h00000000, enable_r};
		end else begin
			rd_hit = 1'b0;
		end
	end

	assign wr_count   = wr_en & (paddr == PMT_OFS_COUNT);
	assign wr_period  = wr_en & (paddr == PMT_OFS_PERIOD);
	assign wr_control = wr_en & (paddr == PMT_OFS_CONTROL);
	assign wr_flag    = wr_en & (paddr == PMT_OFS_FLAG);
	assign wr_enable  = wr_en & (paddr == PMT_OFS_ENABLE);

	// one wait state so that every bus output comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc & ~pready_r;
			pslverr_r <= acc & ~pready_r & ~rd_hit;
			if (acc & ~pready_r & ~pwrite) begin
				prdata_r <= rd_val;
			end
		end
	end

	// ==================================================
	// control fields
	logic [1:0] pre_sel;
	logic       run;
	logic [3:0] post_sel;
	logic       scaler_clr;

	assign pre_sel    = control_r[PMT_CTL_PRE_LSB +: 2];
	assign run        = control_r[PMT_CTL_RUN_BIT];
	assign post_sel   = control_r[PMT_CTL_POST_MSB:PMT_CTL_POST_LSB];
	assign scaler_clr = wr_count | wr_control;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_r <= PMT_RST_CONTROL;
		end else if (wr_control) begin
			control_r <= pwdata[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_r <= PMT_RST_PERIOD;
		end else if (wr_period) begin
			period_r <= pwdata[7:0];
		end
	end

	// ==================================================
	// instruction clock: one tick every IC_DIV core clocks
	logic ic_tick;
	assign ic_tick = (qdiv_r == 4'(IC_DIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qdiv_r <= '0;
		end else if (ic_tick) begin
			qdiv_r <= '0;
		end else begin
			qdiv_r <= qdiv_r + 4'h1;
		end
	end

	// ==================================================
	// prescaler; frozen while stopped to save power
	logic pre_tick;
	assign pre_tick = run & ic_tick & ((pre_cnt_r & pre_mask(pre_sel)) == pre_mask(pre_sel));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_r <= '0;
		end else if (scaler_clr) begin
			pre_cnt_r <= '0;
		end else if (run & ic_tick) begin
			pre_cnt_r <= pre_cnt_r + 4'h1;
		end
	end

	// ==================================================
	// count and match
	logic hit;
	logic post_fire;
	assign hit       = pre_tick & (count_r == period_r) & ~wr_count;
	assign post_fire = hit & ~wr_control & (post_cnt_r == post_sel);

	// a software write to the count wins over a coincident tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= PMT_RST_COUNT;
		end else if (wr_count) begin
			count_r <= pwdata[7:0];
		end else if (hit) begin
			count_r <= '0;
		end else if (pre_tick) begin
			count_r <= count_r + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_cnt_r <= '0;
		end else if (scaler_clr) begin
			post_cnt_r <= '0;
		end else if (hit) begin
			post_cnt_r <= (post_cnt_r == post_sel) ? 4'h0 : post_cnt_r + 4'h1;
		end
	end

	// unscaled match to pwm, halved toggle as serial shift clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_r <= 1'b0;
			shift_r <= 1'b0;
		end else begin
			match_r <= hit;
			shift_r <= shift_r ^ hit;
		end
	end

	// ==================================================
	// interrupt: sticky flag, set beats write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else if (post_fire) begin
			flag_r <= 1'b1;
		end else if (wr_flag & pwdata[PMT_FLAG_BIT]) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= 1'b0;
		end else if (wr_enable) begin
			enable_r <= pwdata[PMT_FLAG_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= flag_r & enable_r;
		end
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign irq           = irq_r;
	assign pwm_timebase  = match_r;
	assign ssp_shift_clk = shift_r;

	// ==================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel & ~penable;
	endsequence
	sequence s_ack;
		pready_r ##1 ~pready_r;
	endsequence

	chk_apb_one_wait: assert property (s_setup ##1 acc |=> s_ack)
		else $error("apb answer not after one wait state");
	chk_count_step: assert property (pre_tick & ~hit & ~wr_count |=> count_r == $past(count_r) + 8'h01)
		else $error("count did not advance by one");
	chk_presc_ratio: assert property (pre_tick & ~scaler_clr |-> (pre_cnt_r & pre_mask(pre_sel)) == pre_mask(pre_sel))
		else $error("prescaled tick at wrong prescaler count");
	chk_match_out: assert property (match_r |-> $past(count_r) == $past(period_r) && count_r == 8'h00)
		else $error("match pulse without equal count");
	chk_match_clear: assert property (hit |=> count_r == 8'h00 ##0 match_r)
		else $error("count not cleared after match");
	chk_scaler_clear: assert property (scaler_clr |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0)
		else $error("scalers not cleared by write");
	chk_ctrl_keeps: assert property (wr_control & ~pre_tick |=> count_r == $past(count_r))
		else $error("control write changed count");
	chk_stop_hold: assert property (~run & ~wr_count |=> $stable(count_r))
		else $error("stopped timer counted");
	chk_post_fire: assert property ($rose(flag_r) |-> $past(post_cnt_r) == $past(post_sel) && $past(hit))
		else $error("flag set at wrong postscale count");
	chk_flag_sticky: assert property (flag_r & ~(wr_flag & pwdata[PMT_FLAG_BIT]) |=> flag_r)
		else $error("flag cleared without software");
	chk_irq_gate: assert property (irq_r |-> $past(flag_r) & $past(enable_r))
		else $error("interrupt without enable");
	chk_ctrl_bit7: assert property (pready_r & ~pwrite & (paddr == PMT_OFS_CONTROL) |-> prdata_r[7] == 1'b0)
		else $error("control bit 7 read as one");

	// ==================================================
	// check helpers: spacing counters kept apart from the datapath counters
	// the gap counter is restarted on stop and on scaler clear, where the prescaler phase is legally unknown
	logic [4:0] core_cnt_r;
	logic [4:0] gap_cnt_r;
	logic       gap_ok_r;
	logic [4:0] gap_want;

	assign gap_want = (pre_sel == 2'b00) ? 5'h01 : ((pre_sel == 2'b01) ? 5'h04 : 5'h10);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_cnt_r <= '0;
		end else if (ic_tick) begin
			core_cnt_r <= '0;
		end else begin
			core_cnt_r <= core_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt_r <= '0;
			gap_ok_r  <= 1'b0;
		end else if (scaler_clr | ~run) begin
			gap_cnt_r <= '0;
			gap_ok_r  <= 1'b0;
		end else if (pre_tick) begin
			gap_cnt_r <= '0;
			gap_ok_r  <= 1'b1;
		end else if (ic_tick) begin
			gap_cnt_r <= gap_cnt_r + 5'h01;
		end
	end

	sequence s_flag_then_irq;
		flag_r ##1 irq_r;
	endsequence

	chk_ic_spacing: assert property (ic_tick |-> core_cnt_r == 5'(IC_DIV - 1))
		else $error("instruction tick at wrong spacing");
	chk_presc_gap: assert property (pre_tick & gap_ok_r & ~scaler_clr |-> gap_cnt_r + 5'h01 == gap_want)
		else $error("prescaled ticks at wrong spacing");
	chk_post_step: assert property (hit & ~scaler_clr & (post_cnt_r != post_sel) |=>
		post_cnt_r == $past(post_cnt_r) + 4'h1)
		else $error("postscaler did not advance on match");
	chk_flag_set: assert property (post_fire |=> flag_r)
		else $error("flag not set at postscale count");
	chk_flag_clear: assert property (wr_flag & pwdata[PMT_FLAG_BIT] & ~post_fire |=> ~flag_r)
		else $error("flag not cleared by software");
	chk_irq_chain: assert property (post_fire & enable_r & ~wr_enable |=> s_flag_then_irq)
		else $error("enabled flag gave no interrupt");
	chk_irq_masked: assert property (~enable_r |=> ~irq_r)
		else $error("interrupt while masked");
	chk_ctrl_write: assert property (wr_control |=> control_r == $past(pwdata[6:0]))
		else $error("control write did not land");
	chk_pre_freeze: assert property (~run & ~scaler_clr |=> $stable(pre_cnt_r))
		else $error("stopped prescaler moved");
	chk_count_write: assert property (wr_count |=> count_r == $past(pwdata[7:0]))
		else $error("count write did not land");
	chk_period_write: assert property (wr_period |=> period_r == $past(pwdata[7:0]))
		else $error("period write did not land");
	chk_rd_count: assert property (pready_r & ~pwrite & (paddr == PMT_OFS_COUNT) |->
		prdata_r == {24'h000000, $past(count_r)})
		else $error("count read returned wrong data");
	chk_rd_period: assert property (pready_r & ~pwrite & (paddr == PMT_OFS_PERIOD) |->
		prdata_r == {24'h000000, $past(period_r)})
		else $error("period read returned wrong data");
	chk_rd_control: assert property (pready_r & ~pwrite & (paddr == PMT_OFS_CONTROL) |->
		prdata_r == {25'h0000000, $past(control_r)})
		else $error("control read returned wrong data");
	chk_wr_ignored: assert property (pslverr_r & pwrite |=>
		period_r == $past(period_r) && control_r == $past(control_r))
		else $error("unmapped write changed a register");
	chk_shift_toggle: assert property (hit |=> ssp_shift_clk != $past(ssp_shift_clk))
		else $error("shift clock did not toggle on match");
	chk_shift_hold: assert property (~hit |=> $stable(ssp_shift_clk))
		else $error("shift clock moved without match");
	chk_ready_after_acc: assert property (pready_r |-> $past(acc))
		else $error("ready without access phase");
	chk_err_ack: assert property (pslverr_r |-> pready_r)
		else $error("error response without ready");

endmodule
`default_nettype wire

// ===== verilog/pmt_pkg.sv
// constants, register map and field layout of the 8-bit period match timer
`default_nettype none
package pmt_pkg;
	// ==================================================
	// register offsets (byte addresses)
	localparam logic [11:0] PMT_OFS_COUNT   = 12'h000;
	localparam logic [11:0] PMT_OFS_PERIOD  = 12'h004;
	localparam logic [11:0] PMT_OFS_CONTROL = 12'h008;
	localparam logic [11:0] PMT_OFS_FLAG    = 12'h00C;
	localparam logic [11:0] PMT_OFS_ENABLE  = 12'h010;
	// ==================================================
	// control fields
	localparam int PMT_CTL_PRE_LSB  = 0;
	localparam int PMT_CTL_RUN_BIT  = 2;
	localparam int PMT_CTL_POST_LSB = 3;
	localparam int PMT_CTL_POST_MSB = 6;
	localparam int PMT_FLAG_BIT     = 0;
	// ==================================================
	// reset values
	localparam logic [7:0] PMT_RST_COUNT   = 8'h00;
	localparam logic [7:0] PMT_RST_PERIOD  = 8'hFF;
	localparam logic [6:0] PMT_RST_CONTROL = 7'h00;
	// ==================================================
	// timing: core clock cycles per instruction cycle, prescaler masks
	localparam int         PMT_IC_DIV   = 4;
	localparam logic [3:0] PMT_PRE_M1   = 4'h0;
	localparam logic [3:0] PMT_PRE_M4   = 4'h3;
	localparam logic [3:0] PMT_PRE_M16  = 4'hF;
endpackage
`default_nettype wire

// ===== dv/pmt_far_model.sv
// far-side model: pwm time base user and serial port shift clock user
`timescale 1ns/1ps
`default_nettype none
module pmt_far_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// timer outputs
	input  wire logic        pwm_timebase,
	input  wire logic        ssp_shift_clk,
	// tallies
	output logic      [15:0] n_match,
	output logic      [15:0] n_toggle
);
	logic last_r;
	// ==================================================
	// each unscaled pulse is one pwm period start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_match <= 16'h0000;
		end else if (pwm_timebase) begin
			n_match <= n_match + 16'h0001;
		end
	end
	// ==================================================
	// shift clock edges, counted as level changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r   <= 1'b0;
			n_toggle <= 16'h0000;
		end else begin
			last_r <= ssp_shift_clk;
			if (last_r != ssp_shift_clk) begin
				n_toggle <= n_toggle + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/period_match_timer_8bit_test.sv
// self-checking bench for the 8-bit period match timer
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_8bit_test;
	import pmt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, irq, pwm_timebase, ssp_shift_clk;
	logic [15:0] n_match, n_toggle;
	int          mismatches, n_tests, n;
	logic [31:0] q;
	logic        e;
	int          divs[4] = '{1, 4, 16, 16};
	int          sels[3] = '{0, 2, 15};
	pmt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .pwm_timebase(pwm_timebase), .ssp_shift_clk(ssp_shift_clk));
	pmt_far_model i_far (.pclk(pclk), .presetn(presetn), .pwm_timebase(pwm_timebase),
		.ssp_shift_clk(ssp_shift_clk), .n_match(n_match), .n_toggle(n_toggle));
	// ==================================================
	// tasks
	task automatic stop_test();
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// one apb transfer; holds the request until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// cycles between two consecutive match pulses
	task automatic gap();
		do @(posedge pclk); while (pwm_timebase !== 1'b1);
		n = 0;
		do begin @(posedge pclk); n++; end while (pwm_timebase !== 1'b1 && n < 2000);
	endtask
	// ==================================================
	// clock, watchdog
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
	// ==================================================
	// tests
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(PMT_OFS_COUNT, 32'h00);
		rd(PMT_OFS_PERIOD, 32'hFF);
		rd(PMT_OFS_CONTROL, 32'h00);
		wr(PMT_OFS_CONTROL, 32'hFF);
		rd(PMT_OFS_CONTROL, 32'h7F);
		xfer(1'b0, 12'h014, 32'h0);
		chk({q[30:0], e}, 32'h1);
		wr(PMT_OFS_CONTROL, 32'h00);
		wr(PMT_OFS_COUNT, 32'h02);
		rd(PMT_OFS_COUNT, 32'h02);
		wr(PMT_OFS_PERIOD, 32'h03);
		rd(PMT_OFS_PERIOD, 32'h03);
		repeat (60) @(posedge pclk);
		rd(PMT_OFS_COUNT, 32'h02);
		wr(PMT_OFS_CONTROL, 32'h78);
		rd(PMT_OFS_COUNT, 32'h02);
		// period of matches for every prescale code
		for (int i = 0; i < 4; i++) begin
			wr(PMT_OFS_CONTROL, 32'h04 | i);
			gap();
			chk(32'(n), 32'(4 * divs[i] * PMT_IC_DIV));
		end
		// postscale ratio: pulses counted up to the interrupt
		wr(PMT_OFS_ENABLE, 32'h1);
		foreach (sels[k]) begin
			wr(PMT_OFS_CONTROL, 32'h00);
			wr(PMT_OFS_FLAG, 32'h1);
			// irq is a registered copy of flag and enable, so it trails the clear by one edge
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
			wr(PMT_OFS_CONTROL, 32'h04 | (sels[k] << 3));
			n = 0;
			for (int c = 0; c < 2000 && irq !== 1'b1; c++) begin
				@(posedge pclk);
				if (pwm_timebase === 1'b1) n++;
			end
			chk(32'(n), 32'(sels[k] + 1));
		end
		// masked: flag stays set, no request
		wr(PMT_OFS_CONTROL, 32'h00);
		wr(PMT_OFS_ENABLE, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		rd(PMT_OFS_FLAG, 32'h1);
		wr(PMT_OFS_FLAG, 32'h1);
		rd(PMT_OFS_FLAG, 32'h0);
		chk(32'(n_match != 16'h0000), 32'h1);
		chk(32'(n_toggle), 32'(n_match));
		// reset in mid-run with the timer going
		wr(PMT_OFS_PERIOD, 32'h10);
		wr(PMT_OFS_CONTROL, 32'h04);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(PMT_OFS_COUNT, 32'h00);
		rd(PMT_OFS_PERIOD, 32'hFF);
		stop_test();
	end
endmodule
`default_nettype wire
